/* File: shared/fswd_pkg.sv */
// constants and state types shared by the failsafe window watchdog
package fswd_pkg;

	//------------------------------------------------------------
	// trigger window, in time-base clocks
	//------------------------------------------------------------
	localparam logic [7:0] WIN_LO_STRICT = 8'h50; // 80: lower bound while not ok
	localparam logic [7:0] WIN_HI_STRICT = 8'ha9; // 169: upper bound while not ok
	localparam logic [7:0] WIN_LO_WIDE = 8'h4f; // 79: lower bound once ok
	localparam logic [7:0] WIN_HI_WIDE = 8'haa; // 170: upper bound once ok
	localparam logic [7:0] DROPOUT_CYC = 8'hfa; // 250 clocks with no trigger
	localparam logic [7:0] IVL_RESET = 8'h00; // no reference edge yet
	localparam logic [7:0] IVL_START = 8'h01; // value loaded on a trigger edge

	//------------------------------------------------------------
	// score counter
	//------------------------------------------------------------
	localparam logic [1:0] SCORE_MIN = 2'h0;
	localparam logic [1:0] SCORE_MAX = 2'h3;
	localparam logic [1:0] SCORE_STEP = 2'h1;

	//------------------------------------------------------------
	// supply fault filter, in clocks (plain defaults)
	//------------------------------------------------------------
	localparam logic [7:0] DEBOUNCE_CYC = 8'h08;
	localparam logic [7:0] RSTDLY_CYC = 8'h20;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// supply supervisor states
	typedef enum logic [1:0] {
		SUP_RUN = 2'b00,
		SUP_DEBOUNCE = 2'b01,
		SUP_DELAY = 2'b10
	} fswd_sup_t;

endpackage

/* File: shared/fswd_trig_if.sv */
// trigger edge carrier between the input conditioner and the watchdog core
`timescale 1ns/100ps
interface fswd_trig_if;
	logic edge_pulse; // one clock per rising edge of the trigger
	logic level; // synchronised trigger level

	modport src (
		output edge_pulse,
		output level
	);
	modport dst (
		input edge_pulse,
		input level
	);
endinterface

/* File: hw/fswd_trig_sync.sv */
// trigger synchroniser and rising edge detector
`timescale 1ns/100ps
module fswd_trig_sync (
	// clock, reset and enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// raw trigger from the microcontroller
	input wire logic trigger_in,
	// conditioned trigger
	fswd_trig_if.src trig
);

	typedef struct packed {
		logic meta; // first stage, read only by the second
		logic sync;
		logic prev;
		logic edge_seen;
	} fswd_sync_t;

	fswd_sync_t st_reg;
	fswd_sync_t st_next;

	//------------------------------------------------------------
	// two-stage sync, then edge compare on the clean copy
	//------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.meta = trigger_in;
		st_next.sync = st_reg.meta;
		st_next.prev = st_reg.sync;
		st_next.edge_seen = st_reg.sync & ~st_reg.prev;
	end

	// state register, frozen while ce is low
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign trig.edge_pulse = st_reg.edge_seen;
	assign trig.level = st_reg.sync;

endmodule

/* File: hw/fswd_watchdog.sv */
// failsafe window watchdog core: trigger scoring, supply reset, output gating
`timescale 1ns/100ps
//------------------------------------------------------------
//------------------------------------------------------------
module fswd_watchdog (
	// clock, reset and enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// microcontroller inputs
	input wire logic trigger_in,
	input wire logic relay_request_in,
	// health inputs from the analog side
	input wire logic oscillator_fail_in,
	input wire logic undervolt_in,
	input wire logic overvolt_in,
	// watchdog status
	output logic window_ok_flag,
	output logic trig_too_fast,
	output logic trig_too_slow,
	output logic trig_dropout,
	// supply reset output, low while in reset
	output logic reset_n_out,
	// relay open-collector pin
	output logic relay_pin_out,
	output logic relay_pin_oe,
	// enable open-collector pin
	output logic enable_pin_out,
	output logic enable_pin_oe
);

	//------------------------------------------------------------
	// state of the whole core
	//------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ivl; // clocks since the last trigger edge
		logic [1:0] score; // up/down score counter
		logic ok; // set/reset flag behind window_ok_flag
		fswd_pkg::fswd_sup_t sup; // supply supervisor state
		logic [7:0] sup_cnt; // debounce and reset delay count
		logic fast; // last verdict: period too short
		logic slow; // last verdict: period too long
		logic drop; // dropout seen since the last edge
		logic rst_n; // reset output level
		logic relay_on; // relay driver pulling low
		logic enable_on; // enable driver pulling low
	} fswd_core_t;

	fswd_core_t st_reg;
	fswd_core_t st_next;

	//------------------------------------------------------------
	// trigger conditioning
	//------------------------------------------------------------
	fswd_trig_if trig ();

	// edge detection kept apart so the first sync stage stays private
	fswd_trig_sync u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.trigger_in(trigger_in),
		.trig(trig.src)
	);

	//------------------------------------------------------------
	// window decode
	//------------------------------------------------------------
	logic [7:0] win_lo;
	logic [7:0] win_hi;
	logic no_ref;
	logic is_fast;
	logic is_slow;
	logic is_good;
	logic supply_fault;
	logic in_reset;
	logic dropout_now;
	logic wd_clear;

	// hysteresis: once ok the window widens by one clock on each side
	assign win_lo = st_reg.ok ? fswd_pkg::WIN_LO_WIDE : fswd_pkg::WIN_LO_STRICT;
	assign win_hi = st_reg.ok ? fswd_pkg::WIN_HI_WIDE : fswd_pkg::WIN_HI_STRICT;

	// verdict on the period just closed by an edge
	assign no_ref = (st_reg.ivl == fswd_pkg::IVL_RESET);
	assign is_fast = no_ref | (st_reg.ivl < win_lo);
	assign is_slow = ~no_ref & (st_reg.ivl > win_hi);
	assign is_good = ~is_fast & ~is_slow;

	// health conditions that pull the watchdog back to its start
	assign supply_fault = undervolt_in | overvolt_in;
	assign in_reset = (st_reg.sup == fswd_pkg::SUP_DELAY);
	assign dropout_now = (st_reg.ivl == fswd_pkg::DROPOUT_CYC);
	assign wd_clear = in_reset | oscillator_fail_in;

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// supply supervisor: glitch filter, then a restartable delay
		case (st_reg.sup)
			fswd_pkg::SUP_RUN: begin
				if (supply_fault) begin
					st_next.sup = fswd_pkg::SUP_DEBOUNCE;
					st_next.sup_cnt = fswd_pkg::CNT_ONE;
				end
			end
			fswd_pkg::SUP_DEBOUNCE: begin
				if (!supply_fault) begin
					// too short to count, outputs never moved
					st_next.sup = fswd_pkg::SUP_RUN;
					st_next.sup_cnt = fswd_pkg::CNT_ZERO;
				end else if (st_reg.sup_cnt >= fswd_pkg::DEBOUNCE_CYC - fswd_pkg::CNT_ONE) begin
					st_next.sup = fswd_pkg::SUP_DELAY;
					st_next.sup_cnt = fswd_pkg::CNT_ZERO;
				end else begin
					st_next.sup_cnt = st_reg.sup_cnt + fswd_pkg::CNT_ONE;
				end
			end
			fswd_pkg::SUP_DELAY: begin
				if (supply_fault) begin
					// a fresh pulse starts the delay over, so it may stretch
					st_next.sup_cnt = fswd_pkg::CNT_ZERO;
				end else if (st_reg.sup_cnt >= fswd_pkg::RSTDLY_CYC - fswd_pkg::CNT_ONE) begin
					st_next.sup = fswd_pkg::SUP_RUN;
					st_next.sup_cnt = fswd_pkg::CNT_ZERO;
				end else begin
					st_next.sup_cnt = st_reg.sup_cnt + fswd_pkg::CNT_ONE;
				end
			end
			default: begin
				// unknown code falls back into reset, the safe side
				st_next.sup = fswd_pkg::SUP_DELAY;
				st_next.sup_cnt = fswd_pkg::CNT_ZERO;
			end
		endcase

		// watchdog scoring
		if (wd_clear) begin
			// supply reset or dead oscillator: back to score 0, fault
			st_next.ivl = fswd_pkg::IVL_RESET;
			st_next.score = fswd_pkg::SCORE_MIN;
			st_next.ok = 1'b0;
			st_next.fast = 1'b0;
			st_next.slow = 1'b0;
			st_next.drop = 1'b0;
		end else if (trig.edge_pulse) begin
			// every edge restarts the interval and steps the score
			st_next.ivl = fswd_pkg::IVL_START;
			st_next.fast = is_fast;
			st_next.slow = is_slow;
			st_next.drop = 1'b0;
			if (is_good) begin
				if (st_reg.score != fswd_pkg::SCORE_MAX) begin
					st_next.score = st_reg.score + fswd_pkg::SCORE_STEP;
				end // saturates at the top
				if (st_reg.score >= fswd_pkg::SCORE_MAX - fswd_pkg::SCORE_STEP) begin
					st_next.ok = 1'b1;
				end
			end else begin
				if (st_reg.score != fswd_pkg::SCORE_MIN) begin
					st_next.score = st_reg.score - fswd_pkg::SCORE_STEP;
				end // saturates at the bottom
				if (st_reg.score <= fswd_pkg::SCORE_STEP) begin
					st_next.ok = 1'b0;
				end
			end
		end else if (dropout_now) begin
			// trigger lost: score and ok drop at once, interval holds
			st_next.score = fswd_pkg::SCORE_MIN;
			st_next.ok = 1'b0;
			st_next.drop = 1'b1;
		end else if (!no_ref) begin
			// count only after a reference edge; stops at the dropout mark
			st_next.ivl = st_reg.ivl + fswd_pkg::CNT_ONE;
		end

		// output gating, taken from the next flags so pins move with ok
		st_next.rst_n = (st_next.sup != fswd_pkg::SUP_DELAY);
		st_next.relay_on = relay_request_in & st_next.ok & st_next.rst_n;
		st_next.enable_on = ~st_next.ok | ~st_next.rst_n;
	end

	//------------------------------------------------------------
	// state register
	//------------------------------------------------------------
	// reset lands in the power-on delay with score 0 and ok low
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_reg.ivl <= fswd_pkg::IVL_RESET;
			st_reg.score <= fswd_pkg::SCORE_MIN;
			st_reg.ok <= 1'b0;
			st_reg.sup <= fswd_pkg::SUP_DELAY;
			st_reg.sup_cnt <= fswd_pkg::CNT_ZERO;
			st_reg.fast <= 1'b0;
			st_reg.slow <= 1'b0;
			st_reg.drop <= 1'b0;
			st_reg.rst_n <= 1'b0;
			st_reg.relay_on <= 1'b0;
			st_reg.enable_on <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	//------------------------------------------------------------
	// outputs, each straight from a state flip-flop, except the two open-collector data bits, which are tied low
	//------------------------------------------------------------
	assign window_ok_flag = st_reg.ok;
	assign trig_too_fast = st_reg.fast;
	assign trig_too_slow = st_reg.slow;
	assign trig_dropout = st_reg.drop;
	assign reset_n_out = st_reg.rst_n;

	// open collector: the data bit is a constant low, only the enable moves
	assign relay_pin_out = 1'b0;
	assign relay_pin_oe = st_reg.relay_on;
	assign enable_pin_out = 1'b0;
	assign enable_pin_oe = st_reg.enable_on;

endmodule

/* File: sim/fswd_mcu_model.sv */
// microcontroller stand-in driving the trigger pulse train
`timescale 1ns/100ps
module fswd_mcu_model (
	// time base
	input wire logic mclk,
	// pulse period in clocks, zero stops the train
	input wire logic [8:0] period,
	// trigger to the watchdog
	output logic trigger_in
);
	logic [8:0] cnt_reg = 9'h000;
	logic [8:0] cnt_next;
	initial trigger_in = 1'b0;
	// steady rate, half high half low; a rise every period clocks
	always @(negedge mclk) begin
		cnt_next = (cnt_reg + 9'h001 >= period) ? 9'h000 : cnt_reg + 9'h001;
		if (period == 9'h000) begin
			cnt_next = 9'h000;
		end
		cnt_reg <= cnt_next;
		trigger_in <= (period != 9'h000) && (cnt_next < (period >> 1));
	end
endmodule

/* File: sim/fswd_watchdog_chk.sv */
// port assertions for the failsafe window watchdog
`timescale 1ns/100ps
module fswd_watchdog_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// inputs
	input wire logic relay_request_in,
	input wire logic oscillator_fail_in,
	input wire logic undervolt_in,
	input wire logic overvolt_in,
	// outputs
	input wire logic window_ok_flag,
	input wire logic trig_too_fast,
	input wire logic trig_too_slow,
	input wire logic trig_dropout,
	input wire logic reset_n_out,
	input wire logic relay_pin_out,
	input wire logic relay_pin_oe,
	input wire logic enable_pin_out,
	input wire logic enable_pin_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [3:0] flt_run_reg;
	// run of supply fault samples, saturating so it never wraps
	always_ff @(posedge mclk) begin
		if (!(undervolt_in | overvolt_in)) begin
			flt_run_reg <= 4'h0;
		end else if (flt_run_reg != 4'hf) begin
			flt_run_reg <= flt_run_reg + 4'h1;
		end
	end
	sequence s_relay_held;
		(window_ok_flag && relay_request_in && reset_n_out)[*2];
	endsequence
	sequence s_in_reset;
		(!reset_n_out)[*2];
	endsequence
	a_relay_follow: assert property (s_relay_held |=> relay_pin_oe || !window_ok_flag || !reset_n_out)
		else $error("relay not driven while ok");
	a_relay_request: assert property (relay_pin_oe |-> $past(relay_request_in))
		else $error("relay driven without request");
	a_reset_safe: assert property (s_in_reset |-> !relay_pin_oe && enable_pin_oe && !window_ok_flag)
		else $error("outputs not safe in reset");
	a_pins_low: assert property (relay_pin_out == 1'b0 && enable_pin_out == 1'b0)
		else $error("open collector data not low");
	a_osc_clear: assert property (oscillator_fail_in |=> !window_ok_flag && !relay_pin_oe && enable_pin_oe)
		else $error("oscillator fail did not clear");
	// the fall is seen one edge after the eighth fault sample, so the run already reads 8
	a_debounce_len: assert property ($fell(reset_n_out) |-> flt_run_reg >= 4'h8)
		else $error("reset on short supply pulse");
	a_dropout_ok: assert property ($rose(trig_dropout) |-> !window_ok_flag && !relay_pin_oe)
		else $error("dropout kept ok");
	a_ok_rise: assert property ($rose(window_ok_flag) |-> reset_n_out && !trig_too_fast && !trig_too_slow)
		else $error("ok set without good trigger");
	a_ok_fall: assert property ($fell(window_ok_flag) |-> !reset_n_out || trig_too_fast || trig_too_slow
		|| trig_dropout || $past(oscillator_fail_in | undervolt_in | overvolt_in))
		else $error("ok cleared without cause");
endmodule

/* File: sim/fswd_watchdog_bench.sv */
// self-checking bench for the failsafe window watchdog
`timescale 1ns/100ps
module fswd_watchdog_bench;
	logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, relay_request_in = 1'b0;
	logic oscillator_fail_in = 1'b0, undervolt_in = 1'b0, overvolt_in = 1'b0;
	logic [8:0] period = 9'h000;
	logic trigger_in, window_ok_flag, trig_too_fast, trig_too_slow, trig_dropout;
	logic reset_n_out, relay_pin_out, relay_pin_oe, enable_pin_out, enable_pin_oe;
	int error_cnt = 0, n_compared = 0;
	// status: ok, fast, slow, dropout, reset_n, relay on, enable on
	wire [6:0] st = {window_ok_flag, trig_too_fast, trig_too_slow, trig_dropout,
		reset_n_out, relay_pin_oe, enable_pin_oe};
	always #5 mclk = ~mclk;
	fswd_mcu_model i_fswd_mcu_model (.mclk, .period, .trigger_in);
	fswd_watchdog i_fswd_watchdog (.mclk, .nrst, .ce, .trigger_in, .relay_request_in,
		.oscillator_fail_in, .undervolt_in, .overvolt_in, .window_ok_flag, .trig_too_fast,
		.trig_too_slow, .trig_dropout, .reset_n_out, .relay_pin_out, .relay_pin_oe,
		.enable_pin_out, .enable_pin_oe);
	task automatic check(input logic [6:0] mask, input logic [6:0] exp);
		n_compared++;
		if ((st & mask) !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, st & mask);
		end
	endtask
	task automatic clk(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// n trigger rises, then let the verdict pipeline settle
	task automatic edges(input int n);
		repeat (n) @(posedge trigger_in);
		clk(6);
	endtask
	task automatic t_reset;
		relay_request_in = 1'b1;
		clk(2);
		check(7'h7f, 7'h01);
		for (int i = 0; i < 40 && reset_n_out !== 1'b1; i++) clk(1);
		check(7'h7f, 7'h05);
		$display("reset test done");
	endtask
	task automatic t_good;
		period = 9'h064;
		edges(3);
		check(7'h7f, 7'h05);
		edges(1);
		check(7'h7f, 7'h46);
		relay_request_in = 1'b0;
		clk(2);
		check(7'h03, 7'h00);
		relay_request_in = 1'b1;
		clk(2);
		check(7'h03, 7'h02);
		$display("good test done");
	endtask
	task automatic t_fast;
		period = 9'h028;
		edges(2);
		check(7'h7f, 7'h66);
		edges(1);
		check(7'h7f, 7'h25);
		$display("fast test done");
	endtask
	// upper band edge, then widened edge once ok, then too slow
	task automatic t_band;
		period = 9'h0a9;
		edges(5);
		check(7'h7f, 7'h46);
		period = 9'h0aa;
		edges(2);
		check(7'h7f, 7'h46);
		period = 9'h0c8;
		edges(3);
		check(7'h7f, 7'h15);
		$display("band test done");
	endtask
	task automatic t_drop;
		period = 9'h050;
		edges(5);
		check(7'h7f, 7'h46);
		period = 9'h000;
		clk(240);
		check(7'h7f, 7'h46);
		clk(20);
		check(7'h7f, 7'h0d);
		$display("dropout test done");
	endtask
	task automatic t_supply;
		period = 9'h064;
		edges(5);
		undervolt_in = 1'b1;
		clk(5);
		undervolt_in = 1'b0;
		clk(3);
		check(7'h7f, 7'h46);
		overvolt_in = 1'b1;
		clk(12);
		check(7'h47, 7'h01);
		overvolt_in = 1'b0;
		clk(20);
		overvolt_in = 1'b1;
		clk(9);
		overvolt_in = 1'b0;
		clk(30);
		check(7'h04, 7'h00);
		clk(8);
		check(7'h04, 7'h04);
		$display("supply test done");
	endtask
	task automatic t_osc;
		edges(5);
		check(7'h7f, 7'h46);
		oscillator_fail_in = 1'b1;
		clk(3);
		check(7'h43, 7'h01);
		oscillator_fail_in = 1'b0;
		$display("oscillator test done");
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk(3);
		nrst = 1'b1;
		t_reset;
		t_good;
		t_fast;
		t_band;
		t_drop;
		t_supply;
		t_osc;
		print_verdict;
	end
	// hang guard, several times the expected run
	initial begin
		clk(20000);
		error_cnt++;
		print_verdict;
	end
endmodule
bind fswd_watchdog fswd_watchdog_chk i_fswd_watchdog_chk (.mclk, .nrst, .relay_request_in,
	.oscillator_fail_in, .undervolt_in, .overvolt_in, .window_ok_flag, .trig_too_fast,
	.trig_too_slow, .trig_dropout, .reset_n_out, .relay_pin_out, .relay_pin_oe,
	.enable_pin_out, .enable_pin_oe);
